/* File: fdc_rate_status_port.sv */
// floppy rate control, controller state and data port registers with byte fifo
// Notes on behaviour
// - rate bits survive soft reset, hardware gives 250k
// - bits 2-4 pick write delay from start track
// - code 111 none, 001-110 steps, 000 default
// - default delay 20.8, 41.67, else 125 ns
// - bit 6 enters manual low power
// - soft reset, data port access or state read leaves low power
// - bit 7 soft reset, clears itself
// - rate codes map to rates and density
// - drive rate type changes only code 01
// - drive type routes rate/density onto pins
// - state register readable anytime, no wait
// - bits 0-3 show drive seek busy
// - bit 4 shows command in progress
// - bit 5 always reads zero
// - bit 6 gives transfer direction
// - bit 7 says host may move byte
// - data port carries all command traffic
// - fifo disabled after any reset
// - fifo inactive at command start, flushed at execution
// - overrun/underrun ends transfer, write pads zeros
// - hardware reset loads rate register 02h

// ==========================================
// byte fifo
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i,
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_state_s;
  fifo_state_s st; // registered state
  fifo_state_s next_st; // next state
  logic push; // byte taken in
  logic pop; // byte handed out

  // honest flags straight from the count
  assign in_ready_o = (st.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (st.cnt != '0);
  assign out_data_o = st.mem[st.rp];
  assign count_o = st.cnt;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // pointer and count update
  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.mem[st.wp] = in_data_i;
      next_st.wp = st.wp + 1'b1;
    end
    if (pop)
      next_st.rp = st.rp + 1'b1;
    next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
    // flush drops stale bytes, wins over traffic
    if (flush_i)
    begin
      next_st.wp = '0;
      next_st.rp = '0;
      next_st.cnt = '0;
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      st <= '0;
    else
      st <= next_st;
  end
endmodule

// ==========================================
// register block
module fdc_rate_status_port #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input fdc_regs_pkg::host_req_s host_i,
  output logic [7:0] rdata_o,
  input wire logic drive_control_reset_i,
  input wire logic [1:0] drive_rate_type_i,
  input wire logic [1:0] drive_type_bits_i,
  input wire logic cmd_busy_i,
  input wire logic [3:0] drive_seek_busy_i,
  input wire logic xfer_enable_i,
  input wire logic transfer_direction_i,
  input wire logic exec_phase_i,
  input wire logic exec_start_i,
  input wire logic fifo_on_i,
  input wire logic [7:0] cur_track_i,
  input wire logic [7:0] start_track_i,
  input wire logic seq_tx_valid_i,
  input wire logic [7:0] seq_tx_data_i,
  output logic seq_tx_ready_o,
  output logic seq_rx_valid_o,
  output logic [7:0] seq_rx_data_o,
  input wire logic seq_rx_ready_i,
  output logic [1:0] rate_select_bits_o,
  output logic density_select_out_o,
  output logic [1:0] drive_density_pins_o,
  output fdc_regs_pkg::data_rate_e data_rate_o,
  output fdc_regs_pkg::write_delay_select_s write_delay_select_o,
  output logic low_power_o,
  output logic soft_reset_o,
  output logic overrun_o,
  output logic underrun_o
);
  import fdc_regs_pkg::*;

  typedef struct packed {
    rate_ctl_s ctl;
    logic swrst;
    logic [7:0] rdata;
    logic dens;
    logic [1:0] pins;
    data_rate_e rate;
    write_delay_select_s pre;
    logic ovr;
    logic udr;
  } port_state_s;
  port_state_s st; // registered state
  port_state_s next_st; // next state
  logic wr_state; // host write at offset 4
  logic rd_state; // host read at offset 4
  logic wr_data; // host write at data port
  logic rd_data; // host read at data port
  logic sw_rst; // either soft reset source
  logic fifo_act; // fifo mode in execution phase
  logic f_in_valid;
  logic f_in_ready;
  logic [7:0] f_in_data;
  logic f_out_valid;
  logic f_out_ready;
  logic [7:0] f_out_data;
  logic [$clog2(FIFO_DEPTH):0] f_cnt;
  logic f_empty;
  logic f_full;
  logic xfer_request; // host may move a byte
  logic [7:0] state_byte;

  // ==========================================
  // decode helpers
  function automatic data_rate_e rate_of(input logic [1:0] code, input logic [1:0] rtype);
    data_rate_e r;
    r = RATE_250;
    unique case (code)
      CODE_1M: r = RATE_1M;
      CODE_500: r = RATE_500;
      CODE_ALT: r = (rtype == RTYPE_3MODE) ? RATE_500 : (rtype == RTYPE_2M) ? RATE_2M : RATE_300;
      default: r = RATE_250;
    endcase
    return r;
  endfunction

  function automatic logic [2:0] steps_of(input logic [2:0] code, input data_rate_e r);
    logic [2:0] s;
    s = code;
    if (code == PRE_NONE)
      s = '0;
    else if (code == PRE_DEFAULT)
      s = (r == RATE_2M || r == RATE_1M) ? STEPS_DEF_FAST : STEPS_DEF_SLOW;
    return s;
  endfunction

  // ==========================================
  // host decode
  // direction picks register
  assign wr_state = host_i.wr && host_i.addr == OFS_STATE;
  assign rd_state = host_i.rd && host_i.addr == OFS_STATE;
  assign wr_data = host_i.wr && host_i.addr == OFS_DATA;
  assign rd_data = host_i.rd && host_i.addr == OFS_DATA;
  assign sw_rst = st.swrst || drive_control_reset_i;

  // ==========================================
  // fifo steering, direction chosen by sequencer
  // only configure turns fifo on
  assign fifo_act = fifo_on_i && exec_phase_i;
  assign f_empty = (f_cnt == '0);
  assign f_full = !f_in_ready;
  assign f_in_valid = transfer_direction_i ? seq_tx_valid_i : wr_data;
  assign f_in_data = transfer_direction_i ? seq_tx_data_i : host_i.wdata;
  assign f_out_ready = transfer_direction_i ? rd_data : (seq_rx_ready_i && !st.udr);
  // sequencer stalls while host has not drained in byte mode
  assign seq_tx_ready_o = transfer_direction_i && f_in_ready && (fifo_act || f_empty);
  assign seq_rx_valid_o = !transfer_direction_i && (st.udr || f_out_valid);
  assign seq_rx_data_o = st.udr ? 8'h00 : f_out_data;

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .flush_i(exec_start_i || sw_rst),
    .in_valid_i(f_in_valid),
    .in_data_i(f_in_data),
    .in_ready_o(f_in_ready),
    .out_valid_o(f_out_valid),
    .out_data_o(f_out_data),
    .out_ready_i(f_out_ready),
    .count_o(f_cnt)
  );

  // ==========================================
  // status byte
  // request when a byte can move
  always_comb
  begin
    if (transfer_direction_i)
      xfer_request = xfer_enable_i && !f_empty;
    else
      xfer_request = xfer_enable_i && (fifo_act ? !f_full : f_empty);
    state_byte = '0;
    state_byte[REQ_BIT] = xfer_request;
    state_byte[DIR_BIT] = transfer_direction_i;
    state_byte[NONDMA_BIT] = 1'b0;
    state_byte[BUSY_BIT] = cmd_busy_i;
    state_byte[3:0] = drive_seek_busy_i;
  end

  // ==========================================
  // next state
  always_comb
  begin
    next_st = st;
    next_st.swrst = 1'b0;
    if (wr_state)
    begin
      next_st.ctl.rate = host_i.wdata[RATE_LSB +: 2];
      next_st.ctl.write_delay_select = host_i.wdata[PRE_LSB +: 3];
      next_st.ctl.low_power = host_i.wdata[LOWPWR_BIT];
      next_st.swrst = host_i.wdata[SWRST_BIT];
    end
    if (rd_state || wr_data || rd_data || sw_rst)
      next_st.ctl.low_power = 1'b0;
    // status sampled same cycle, no wait
    if (rd_state)
      next_st.rdata = state_byte;
    else if (rd_data)
      next_st.rdata = transfer_direction_i ? f_out_data : 8'h00;
    else if (host_i.rd)
      next_st.rdata = 8'h00;
    next_st.rate = rate_of(next_st.ctl.rate, drive_rate_type_i);
    next_st.dens = (next_st.ctl.rate == CODE_1M || next_st.ctl.rate == CODE_500);
    unique case (drive_type_bits_i)
      2'h0: next_st.pins = {next_st.ctl.rate[0], next_st.dens};
      2'h2: next_st.pins = {next_st.ctl.rate[0], next_st.ctl.rate[1]};
      2'h1: next_st.pins = {next_st.ctl.rate[0], !next_st.dens};
      default: next_st.pins = {next_st.ctl.rate[1], next_st.ctl.rate[0]};
    endcase
    next_st.pre.fine = (next_st.rate == RATE_2M);
    next_st.pre.steps = (cur_track_i >= start_track_i) ?
      steps_of(next_st.ctl.write_delay_select, next_st.rate) : 3'h0;
    if (fifo_act && transfer_direction_i && seq_tx_valid_i && f_full)
      next_st.ovr = 1'b1;
    if (fifo_act && !transfer_direction_i && seq_rx_ready_i && f_empty)
      next_st.udr = 1'b1;
    // new command or reset clears the error
    if (!exec_phase_i || exec_start_i || sw_rst)
    begin
      next_st.ovr = 1'b0;
      next_st.udr = 1'b0;
    end
  end

  // ==========================================
  // state register
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st <= '0;
      st.ctl.rate <= RATE_HW_RESET[RATE_LSB +: 2];
      st.ctl.write_delay_select <= RATE_HW_RESET[PRE_LSB +: 3];
      st.rate <= RATE_250;
      st.pre.steps <= STEPS_DEF_SLOW;
    end
    else
      st <= next_st;
  end

  assign rdata_o = st.rdata;
  assign rate_select_bits_o = st.ctl.rate;
  assign density_select_out_o = st.dens;
  assign drive_density_pins_o = st.pins;
  assign data_rate_o = st.rate;
  assign write_delay_select_o = st.pre;
  assign low_power_o = st.ctl.low_power;
  assign soft_reset_o = st.swrst;
  assign overrun_o = st.ovr;
  assign underrun_o = st.udr;

  // ==========================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  property p_swrst_pulse;
    wr_state && host_i.wdata[SWRST_BIT] |=> soft_reset_o ##1 !soft_reset_o;
  endproperty
  a_swrst_pulse: assert property (p_swrst_pulse) else $error("soft reset not one cycle");
  property p_rate_kept;
    soft_reset_o && !wr_state |=> $stable(rate_select_bits_o);
  endproperty
  a_rate_kept: assert property (p_rate_kept) else $error("rate changed by soft reset");
  property p_lowpwr_on;
    wr_state && host_i.wdata[LOWPWR_BIT] && !drive_control_reset_i && !st.swrst |=> low_power_o;
  endproperty
  a_lowpwr_on: assert property (p_lowpwr_on) else $error("low power not entered");
  property p_lowpwr_off;
    low_power_o && (rd_state || rd_data || wr_data) |=> !low_power_o;
  endproperty
  a_lowpwr_off: assert property (p_lowpwr_off) else $error("low power not left");
  property p_state_read;
    rd_state |=> rdata_o[NONDMA_BIT] == 1'b0 &&
      rdata_o[4:0] == {$past(cmd_busy_i), $past(drive_seek_busy_i)};
  endproperty
  a_state_read: assert property (p_state_read) else $error("bad status byte");
  property p_req_bytemode;
    rd_state && !transfer_direction_i && !fifo_act && !f_empty |=> !rdata_o[REQ_BIT];
  endproperty
  a_req_bytemode: assert property (p_req_bytemode) else $error("request while busy");
  property p_density;
    density_select_out_o == (rate_select_bits_o == CODE_1M || rate_select_bits_o == CODE_500);
  endproperty
  a_density: assert property (p_density) else $error("density wrong");
  property p_pins_swap;
    drive_type_bits_i == 2'h3 |=> drive_density_pins_o == rate_select_bits_o;
  endproperty
  a_pins_swap: assert property (p_pins_swap) else $error("pin routing wrong");
  property p_no_write_delay_select;
    st.ctl.write_delay_select == PRE_NONE |-> write_delay_select_o.steps == 3'h0;
  endproperty
  a_no_write_delay_select: assert property (p_no_write_delay_select) else $error("delay with code 111");
  property p_pad;
    underrun_o |-> seq_rx_valid_o && seq_rx_data_o == 8'h00;
  endproperty
  a_pad: assert property (p_pad) else $error("underrun not padded");
  property p_flush;
    exec_start_i |=> f_empty;
  endproperty
  a_flush: assert property (p_flush) else $error("fifo not flushed");
  c_swrst: cover property (soft_reset_o);
  c_overrun: cover property (overrun_o);
  c_fifo_fill: cover property (fifo_act && f_full);
endmodule

/* File: fdc_regs_pkg.sv */
// constants and carrier types for the floppy rate, status and data port registers
package fdc_regs_pkg;
  // ==========================================
  // host port offsets
  localparam logic [2:0] OFS_STATE = 3'h4; // status on read, rate control on write
  localparam logic [2:0] OFS_DATA = 3'h5; // command, data and result bytes
  // ==========================================
  // rate control register layout
  localparam logic [7:0] RATE_HW_RESET = 8'h02; // default write_delay_select, 250 kbps
  localparam int RATE_LSB = 0;
  localparam int PRE_LSB = 2;
  localparam int LOWPWR_BIT = 6;
  localparam int SWRST_BIT = 7;
  // ==========================================
  // rate codes and precompensation codes
  localparam logic [1:0] CODE_1M = 2'h3;
  localparam logic [1:0] CODE_500 = 2'h0;
  localparam logic [1:0] CODE_ALT = 2'h1; // 300k, 500k or 2M by drive rate type
  localparam logic [1:0] RTYPE_3MODE = 2'h1;
  localparam logic [1:0] RTYPE_2M = 2'h2;
  localparam logic [2:0] PRE_DEFAULT = 3'h0;
  localparam logic [2:0] PRE_NONE = 3'h7;
  localparam logic [2:0] STEPS_DEF_FAST = 3'h1; // 20.8 ns at 2M, 41.67 ns at 1M
  localparam logic [2:0] STEPS_DEF_SLOW = 3'h3; // 3 x 41.67 ns = 125 ns
  // ==========================================
  // status register bit positions
  localparam int REQ_BIT = 7;
  localparam int DIR_BIT = 6;
  localparam int NONDMA_BIT = 5;
  localparam int BUSY_BIT = 4;
  // ==========================================
  // types
  typedef enum logic [2:0] {RATE_250, RATE_300, RATE_500, RATE_1M, RATE_2M} data_rate_e;
  typedef struct packed {
    logic [2:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } host_req_s;
  typedef struct packed {
    logic [1:0] rate;
    logic [2:0] write_delay_select;
    logic low_power;
  } rate_ctl_s;
  typedef struct packed {
    logic [2:0] steps; // delay in steps, 0 means none
    logic fine; // step is 20.8 ns, else 41.67 ns
  } write_delay_select_s;
endpackage

/* File: fdc_host_model.sv */
// host side model issuing port cycles to the rate, state and data registers
module fdc_host_model
(
  input wire logic clk_i,
  output fdc_regs_pkg::host_req_s host_o,
  input wire logic [7:0] rdata_i
);
  timeunit 1ns;
  timeprecision 100ps;
  import fdc_regs_pkg::*;
  // ==========================================
  // port cycles
  // idle port from time zero, no stray strobe during reset
  initial host_o = '0;
  // one write strobe across exactly one taking edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i) host_o <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk_i) host_o.wr <= 1'b0;
    #1;
  endtask
  // read strobe; data is registered, so taken after the edge
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_i) host_o <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk_i) host_o.rd <= 1'b0;
    #1 d = rdata_i;
  endtask
  // poll before byte
  // bounded poll so a stuck request flag cannot hang the host
  task automatic xfer(input logic w, input logic [7:0] wd, output logic [7:0] d, output logic ok);
    logic [7:0] s;
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++)
    begin
      rd(OFS_STATE, s);
      ok = s[REQ_BIT];
    end
    if (w)
      wr(OFS_DATA, wd);
    else
      rd(OFS_DATA, d);
  endtask
endmodule

/* File: tb_fdc_rate_status_port.sv */
// self-checking bench for the rate, state and data port register block
module tb_fdc_rate_status_port;
  timeunit 1ns;
  timeprecision 100ps;
  import fdc_regs_pkg::*;
  // ==========================================
  // stimulus and observed signals
  logic clk_i, rstn_i, ctl_rst, cmd_busy, xen, dir, exph, exst, fon, txv, txr, rxv, rxr;
  logic dens, lowp, srst, ovr, und, ok;
  logic [1:0] rtype, dtype, rsel, pins;
  logic [3:0] seek;
  logic [7:0] rdata, cur, st, txd, rxd, d;
  host_req_s host;
  data_rate_e rate;
  write_delay_select_s pre;
  int miscompares = 0;
  int compares = 0;
`define CHK(g, e, m) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %0t %s", $time, m); end end
  // ==========================================
  // design and host
  fdc_rate_status_port #(.FIFO_DEPTH(16)) u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .host_i(host),
    .rdata_o(rdata), .drive_control_reset_i(ctl_rst), .drive_rate_type_i(rtype),
    .drive_type_bits_i(dtype), .cmd_busy_i(cmd_busy), .drive_seek_busy_i(seek),
    .xfer_enable_i(xen),
    .transfer_direction_i(dir), .exec_phase_i(exph), .exec_start_i(exst), .fifo_on_i(fon),
    .cur_track_i(cur), .start_track_i(st), .seq_tx_valid_i(txv), .seq_tx_data_i(txd),
    .seq_tx_ready_o(txr), .seq_rx_valid_o(rxv), .seq_rx_data_o(rxd), .seq_rx_ready_i(rxr),
    .rate_select_bits_o(rsel), .density_select_out_o(dens), .drive_density_pins_o(pins),
    .data_rate_o(rate), .write_delay_select_o(pre), .low_power_o(lowp),
    .soft_reset_o(srst), .overrun_o(ovr), .underrun_o(und));
  fdc_host_model u_host (.clk_i(clk_i), .host_o(host), .rdata_i(rdata));
  // 40 mhz clock
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // ==========================================
  // expectations
  function automatic data_rate_e exp_rate(input logic [1:0] c, input logic [1:0] t);
    case (c)
      2'h3: return RATE_1M;
      2'h0: return RATE_500;
      2'h2: return RATE_250;
      default: return (t == 2'h2) ? RATE_2M : ((t == 2'h1) ? RATE_500 : RATE_300);
    endcase
  endfunction
  // pin pair {pin1, pin0} by drive type
  function automatic logic [1:0] exp_pins(input logic [1:0] r, input logic s, input logic [1:0] k);
    case (k)
      2'h0: return {r[0], s};
      2'h2: return {r[0], r[1]};
      2'h1: return {r[0], ~s};
      default: return {r[1], r[0]};
    endcase
  endfunction
  // sequencer offers one byte for one cycle; also used against a full fifo to force overrun
  task automatic push(input logic [7:0] v);
    @(posedge clk_i) {txv, txd} <= {1'b1, v};
    @(posedge clk_i) txv <= 1'b0;
  endtask
  // ==========================================
  // scenarios
  task automatic t_rates;
    data_rate_e r;
    logic s;
    for (int t = 0; t < 3; t++)
    begin
      for (int c = 0; c < 4; c++)
      begin
        @(posedge clk_i) rtype <= 2'(t);
        u_host.wr(OFS_STATE, {6'h00, 2'(c)});
        r = exp_rate(2'(c), 2'(t));
        s = (c == 3 || c == 0);
        `CHK({rate, rsel}, {r, 2'(c)}, "data rate")
        `CHK(dens, s, "density")
        `CHK(pre, (r == RATE_2M) ? 4'h3 : ((r == RATE_1M) ? 4'h2 : 4'h6), "default")
        for (int k = 0; k < 4; k++)
        begin
          @(posedge clk_i) dtype <= 2'(k);
          repeat (2) @(posedge clk_i);
          #1;
          `CHK(pins, exp_pins(2'(c), s, 2'(k)), "pins")
        end
      end
    end
  endtask
  task automatic t_write_delay_select;
    for (int c = 1; c < 8; c++)
    begin
      u_host.wr(OFS_STATE, {3'h0, 3'(c), CODE_ALT});
      `CHK(pre, {(c == 7) ? 3'h0 : 3'(c), 1'b1}, "fast steps")
      u_host.wr(OFS_STATE, {3'h0, 3'(c), 2'h2});
      `CHK(pre, {(c == 7) ? 3'h0 : 3'(c), 1'b0}, "slow steps")
    end
    u_host.wr(OFS_STATE, 8'h16);
    @(posedge clk_i) st <= 8'h10;
    repeat (2) @(posedge clk_i);
    #1;
    `CHK(pre.steps, 3'h0, "below start track")
    @(posedge clk_i) cur <= 8'h10;
    repeat (2) @(posedge clk_i);
    #1;
    `CHK(pre.steps, 3'h5, "at start track")
  endtask
  task automatic t_power;
    u_host.wr(OFS_STATE, 8'h43);
    `CHK(lowp, 1'b1, "low power on")
    u_host.rd(OFS_STATE, d);
    `CHK(lowp, 1'b0, "state read wakes")
    u_host.wr(OFS_STATE, 8'h43);
    u_host.rd(OFS_DATA, d);
    `CHK(lowp, 1'b0, "data read wakes")
    u_host.wr(OFS_STATE, 8'h43);
    @(posedge clk_i) ctl_rst <= 1'b1;
    @(posedge clk_i) ctl_rst <= 1'b0;
    #1;
    `CHK({lowp, rsel}, 3'h3, "control reset keeps rate")
    u_host.wr(OFS_STATE, 8'hc3);
    `CHK({srst, lowp}, 2'h3, "soft reset pulse")
    @(posedge clk_i);
    #1;
    `CHK({srst, lowp, rsel}, 4'h3, "self clearing, awake, rate kept")
    // mid-run hardware reset is asynchronous, checked before any edge
    @(posedge clk_i) rstn_i <= 1'b0;
    #5;
    `CHK({rsel, rate, pre, dens, lowp, srst}, {2'h2, RATE_250, 4'h6, 3'h0}, "hw reset")
    @(posedge clk_i) rstn_i <= 1'b1;
  endtask
  task automatic t_status;
    @(posedge clk_i) {cmd_busy, seek, xen} <= 6'b110100;
    u_host.rd(OFS_STATE, d);
    `CHK(d, 8'h1a, "busy, no request")
    @(posedge clk_i) xen <= 1'b1;
    u_host.rd(OFS_STATE, d);
    `CHK(d, 8'h9a, "write request")
    @(posedge clk_i) {cmd_busy, seek} <= 5'h00;
    u_host.rd(3'h2, d);
    `CHK(d, 8'h00, "unmapped read")
    u_host.xfer(1'b1, 8'h5c, d, ok);
    `CHK({ok, rxv, rxd}, {2'b11, 8'h5c}, "byte out")
    u_host.rd(OFS_STATE, d);
    `CHK(d, 8'h00, "no request while byte held")
    @(posedge clk_i) rxr <= 1'b1;
    @(posedge clk_i) rxr <= 1'b0;
    #1;
    `CHK(rxv, 1'b0, "byte taken")
    @(posedge clk_i) dir <= 1'b1;
    push(8'ha7);
    #1;
    `CHK(txr, 1'b0, "one byte at a time")
    u_host.xfer(1'b0, 8'h00, d, ok);
    `CHK({ok, d}, {1'b1, 8'ha7}, "byte in")
    u_host.rd(OFS_STATE, d);
    `CHK(d, 8'h40, "nothing to read")
  endtask
  task automatic t_fifo;
    @(posedge clk_i) {fon, exph} <= 2'b11;
    for (int i = 0; i < 16; i++)
      push(8'h30 + 8'(i));
    #1;
    `CHK(txr, 1'b0, "full refuses")
    push(8'hee);
    repeat (2) @(posedge clk_i);
    #1;
    `CHK(ovr, 1'b1, "overrun")
    for (int i = 0; i < 16; i++)
    begin
      u_host.xfer(1'b0, 8'h00, d, ok);
      `CHK({ok, d}, {1'b1, 8'h30 + 8'(i)}, "fifo order")
    end
    push(8'h11);
    push(8'h22);
    @(posedge clk_i) exst <= 1'b1;
    @(posedge clk_i) exst <= 1'b0;
    u_host.rd(OFS_STATE, d);
    `CHK({ovr, d}, {1'b0, 8'h40}, "flushed")
    @(posedge clk_i) {dir, rxr} <= 2'b01;
    repeat (2) @(posedge clk_i);
    #1;
    `CHK({und, rxv, rxd}, {2'b11, 8'h00}, "underrun pads")
    @(posedge clk_i) {exph, rxr} <= 2'b00;
    repeat (2) @(posedge clk_i);
    #1;
    `CHK(und, 1'b0, "error clears")
  endtask
  // ==========================================
  // verdict, main sequence and watchdog
  task automatic tally_and_finish;
    if (miscompares == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    {rstn_i, ctl_rst, cmd_busy, xen, dir, exph, exst, fon, txv, rxr} = '0;
    {rtype, dtype, seek, cur, st, txd} = '0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_rates;
    t_write_delay_select;
    t_power;
    t_status;
    t_fifo;
    tally_and_finish;
  end
  // the run needs a few hundred cycles; this is well beyond that
  initial
  begin
    #200000;
    miscompares++;
    tally_and_finish;
  end
endmodule
